// ==== verif/smcp_deser_model.sv ====
`timescale 1ns/10ps
module smcp_deser_model (
    input wire i_clk,
    input wire i_bit_en,
    input wire [4:0] i_len,
    input wire i_fwd_clk,
    input wire i_fwd_clk_oe,
    input wire [2:0] i_lane,
    input wire [2:0] i_lane_oe,
    output logic [29:0] o_frame,
    output int o_clk_errs
);
    logic be_q = 1'b0;
    logic [29:0] acc = 30'h00000000;
    int idx = 0;
    initial o_frame = 30'h00000000;
    initial o_clk_errs = 0;
    // a bit is new only one edge after a bit_en, so stalls are not resampled
    always @(posedge i_clk) begin
        logic [29:0] tmp;
        tmp = acc;
        be_q <= i_bit_en;
        if (i_lane_oe[0] !== 1'b1) begin
            idx <= 0;
        end else if (be_q) begin
            if (i_fwd_clk_oe && i_fwd_clk !== (idx < i_len / 2)) begin
                o_clk_errs <= o_clk_errs + 1;
            end
            tmp[idx] = i_lane[0];
            if (i_lane_oe[1]) begin
                tmp[i_len + idx] = i_lane[1];
            end
            if (i_lane_oe[2]) begin
                tmp[2 * i_len + idx] = i_lane[2];
            end
            acc <= tmp;
            if (idx == i_len - 1) begin
                o_frame <= tmp;
                idx <= 0;
            end else begin
                idx <= idx + 1;
            end
        end
    end
endmodule // smcp_deser_model

// ==== verif/smcp_properties.sv ====
`timescale 1ns/10ps
module smcp_checker #(
    parameter GLITCH = 500
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_transmitter_enable_pin,
    input wire i_lane_select_low,
    input wire i_lane_select_high,
    input wire i_pll_locked,
    input wire o_pll_enable,
    input wire o_monitor_on,
    input wire o_fwd_clk_oe,
    input wire o_serial_lane_zero_oe,
    input wire o_serial_lane_one_oe,
    input wire o_serial_lane_two_oe,
    input wire [3:0] o_mode,
    input wire o_capture_ready,
    input wire o_capture_drop
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    wire [1:0] ls = {i_lane_select_high, i_lane_select_low};
    wire any_oe = o_fwd_clk_oe | o_serial_lane_zero_oe |
        o_serial_lane_one_oe | o_serial_lane_two_oe;
    reg [9:0] low_q;
    // saturating, so a long shutdown never wraps back under the limit
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_q <= 10'h000;
        end else if (i_transmitter_enable_pin) begin
            low_q <= 10'h000;
        end else if (low_q != 10'h3ff) begin
            low_q <= low_q + 10'h001;
        end
    end
    a_acq_outputs_off: assert property (
        o_mode[2] |-> o_pll_enable && !any_oe) else $error("acquire outputs");
    // the clock-off step of a shutdown also reports standby, pll still on
    a_stby_monitor_only: assert property (
        o_mode[1] && low_q < GLITCH |-> o_monitor_on && !o_pll_enable &&
        !any_oe) else $error("standby outputs");
    a_shut_all_off: assert property (
        o_mode[0] |-> !o_pll_enable && !o_monitor_on && !any_oe)
        else $error("shutdown outputs");
    a_shut_filtered: assert property (
        $rose(o_mode[0]) |-> low_q >= GLITCH) else $error("enable filter");
    a_clk_off_first: assert property (
        $fell(o_fwd_clk_oe) && o_serial_lane_zero_oe |=>
        !o_serial_lane_zero_oe && o_mode == 4'h1) else $error("off order");
    a_lane_one_sel: assert property (
        o_serial_lane_one_oe |-> $past(ls) inside {2'h1, 2'h2})
        else $error("lane one enable");
    a_lane_two_sel: assert property (
        o_serial_lane_two_oe |-> $past(ls) == 2'h2) else $error("lane two");
    a_rsv_lanes_off: assert property (
        ls == 2'h3 && $past(ls) == 2'h3 |-> !o_serial_lane_zero_oe &&
        !o_serial_lane_one_oe && !o_serial_lane_two_oe) else $error("rsv");
    a_lanes_after_clk: assert property (
        $rose(o_serial_lane_zero_oe) |-> $past(o_fwd_clk_oe) && o_fwd_clk_oe)
        else $error("lanes before clock");
    a_tx_after_lock: assert property (
        $rose(o_fwd_clk_oe) |-> $past(i_pll_locked, 2)) else $error("no lock");
    a_drop_when_full: assert property (
        o_capture_drop |-> !$past(o_capture_ready) ##1 !o_capture_drop)
        else $error("drop");
    c_transmit: cover property (o_mode[3]);
    c_drop: cover property (o_capture_drop);
    c_rsv_clock: cover property (ls == 2'h3 && o_fwd_clk_oe);
    c_shutdown: cover property ($rose(o_mode[0]));
endmodule // smcp_checker

bind smcp_top smcp_checker u_checker (
    .i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_transmitter_enable_pin(i_transmitter_enable_pin),
    .i_lane_select_low(i_lane_select_low),
    .i_lane_select_high(i_lane_select_high),
    .i_pll_locked(i_pll_locked), .o_pll_enable(o_pll_enable),
    .o_monitor_on(o_monitor_on), .o_fwd_clk_oe(o_fwd_clk_oe),
    .o_serial_lane_zero_oe(o_serial_lane_zero_oe),
    .o_serial_lane_one_oe(o_serial_lane_one_oe),
    .o_serial_lane_two_oe(o_serial_lane_two_oe), .o_mode(o_mode),
    .o_capture_ready(o_capture_ready), .o_capture_drop(o_capture_drop)
);

// ==== verif/smcp_tb_top.sv ====
`timescale 1ns/10ps
module smcp_tb_top;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_transmitter_enable_pin = 1'b1;
    logic i_pclk = 1'b0;
    logic [23:0] i_pixel = 24'h000000;
    logic i_vertical_sync_in = 1'b0;
    logic i_horizontal_sync_in = 1'b0;
    logic i_pixel_valid_in = 1'b0;
    logic i_lane_select_low = 1'b0;
    logic i_lane_select_high = 1'b0;
    logic i_pll_locked = 1'b0;
    logic i_bit_en = 1'b0;
    wire o_pll_enable, o_monitor_on, o_fwd_clk, o_fwd_clk_oe;
    wire [2:0] lane, lane_oe;
    wire [3:0] o_mode;
    wire o_capture_ready, o_capture_drop;
    wire [29:0] rx_frame;
    int rx_clk_errs;
    int fails = 0;
    int checks_done = 0;
    logic run = 1'b0, stall = 1'b0, saw_drop = 1'b0;
    logic [4:0] len = 5'h1e, pc_cnt = 5'h00;
    logic [1:0] sel;
    logic [26:0] pl;
    logic [2:0] exp_oe;
    always #10 i_clk = ~i_clk;
    smcp_top #(.LOCK_CYC(200)) DUT (
        .i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_transmitter_enable_pin(i_transmitter_enable_pin),
        .i_pclk(i_pclk), .i_pixel(i_pixel),
        .i_vertical_sync_in(i_vertical_sync_in),
        .i_horizontal_sync_in(i_horizontal_sync_in),
        .i_pixel_valid_in(i_pixel_valid_in),
        .i_lane_select_low(i_lane_select_low),
        .i_lane_select_high(i_lane_select_high),
        .i_pll_locked(i_pll_locked), .i_bit_en(i_bit_en),
        .o_pll_enable(o_pll_enable), .o_monitor_on(o_monitor_on),
        .o_fwd_clk(o_fwd_clk), .o_fwd_clk_oe(o_fwd_clk_oe),
        .o_serial_lane_zero(lane[0]), .o_serial_lane_zero_oe(lane_oe[0]),
        .o_serial_lane_one(lane[1]), .o_serial_lane_one_oe(lane_oe[1]),
        .o_serial_lane_two(lane[2]), .o_serial_lane_two_oe(lane_oe[2]),
        .o_mode(o_mode), .o_capture_ready(o_capture_ready),
        .o_capture_drop(o_capture_drop)
    );
    smcp_deser_model u_rx (
        .i_clk(i_clk), .i_bit_en(i_bit_en), .i_len(len),
        .i_fwd_clk(o_fwd_clk), .i_fwd_clk_oe(o_fwd_clk_oe),
        .i_lane(lane), .i_lane_oe(lane_oe), .o_frame(rx_frame),
        .o_clk_errs(rx_clk_errs)
    );
    // pixel clock of len clock cycles, high for len/2 of them
    always @(posedge i_clk) begin
        pc_cnt <= (pc_cnt + 5'h01 >= len) ? 5'h00 : pc_cnt + 5'h01;
        i_pclk <= run && (pc_cnt < len / 2);
        i_bit_en <= !stall;
        if (o_capture_drop === 1'b1) begin
            saw_drop <= 1'b1;
        end
    end
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_mode(input logic [3:0] m);
        int n;
        n = 0;
        while (o_mode !== m && n < 3000) begin
            @(negedge i_clk);
            n++;
        end
        chk("mode", {28'h0, m}, {28'h0, o_mode});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(negedge i_clk);
        chk("mode", 32'h2, {28'h0, o_mode});
        chk("monitor", 32'h1, {31'h0, o_monitor_on});
        @(posedge i_clk);
        // a short low pulse must not shut the block down
        i_transmitter_enable_pin <= 1'b0;
        repeat (100) @(posedge i_clk);
        i_transmitter_enable_pin <= 1'b1;
        repeat (600) @(negedge i_clk);
        chk("mode", 32'h2, {28'h0, o_mode});
        for (int m = 0; m < 5; m++) begin
            sel = (m == 4) ? 2'h0 : m[1:0];
            case (m)
                1: pl = 27'h5a5c3e1;
                2: pl = 27'h7ffffff;
                3: pl = 27'h1234567;
                4: pl = 27'h0000001;
                default: pl = 27'h0000000;
            endcase
            exp_oe = (sel == 2'h0) ? 3'h1 : (sel == 2'h1) ? 3'h3 :
                (sel == 2'h2) ? 3'h7 : 3'h0;
            @(posedge i_clk);
            {i_lane_select_high, i_lane_select_low} <= sel;
            len <= (sel == 2'h1) ? 5'h0f : (sel == 2'h2) ? 5'h0a : 5'h1e;
            {i_pixel_valid_in, i_horizontal_sync_in, i_vertical_sync_in,
                i_pixel} <= pl;
            run <= 1'b1;
            wait_mode(4'h4);
            chk("pll_acq", 32'h1, {31'h0, o_pll_enable});
            chk("oe_acq", 32'h0, {28'h0, o_fwd_clk_oe, lane_oe});
            @(posedge i_clk);
            i_pll_locked <= 1'b1;
            if (m == 0) begin
                // receiver stalls: buffer fills and a pixel is dropped
                repeat (100) @(posedge i_clk);
                stall <= 1'b1;
                repeat (200) @(posedge i_clk);
                stall <= 1'b0;
            end
            repeat (300) @(negedge i_clk);
            if (sel != 2'h3) begin
                chk("frame", {2'h0, 2'b00, ~^pl, pl}, {2'h0, rx_frame});
            end
            chk("lane_oe", {29'h0, exp_oe}, {29'h0, lane_oe});
            chk("fwd_oe", 32'h1, {31'h0, o_fwd_clk_oe});
            @(posedge i_clk);
            if (m < 4) begin
                run <= 1'b0;
                wait_mode(4'h2);
            end else begin
                i_transmitter_enable_pin <= 1'b0;
                wait_mode(4'h1);
                chk("monitor_off", 32'h0, {31'h0, o_monitor_on});
            end
            chk("pll_off", 32'h0, {31'h0, o_pll_enable});
            chk("oe_off", 32'h0, {28'h0, o_fwd_clk_oe, lane_oe});
            @(posedge i_clk);
            i_pll_locked <= 1'b0;
        end
        chk("drop", 32'h1, {31'h0, saw_drop});
        chk("clk_errs", 32'h0, rx_clk_errs);
        stop_test;
    end
endmodule // smcp_tb_top

// ==== verilog/smcp_consts.vh ====
`ifndef SMCP_CONSTS_VH
`define SMCP_CONSTS_VH

// system clock
`define SMCP_CLK_PERIOD_NS 20

// enable glitch filter interval, microseconds
`define SMCP_GLITCH_US 10
// lower activity threshold, kilohertz (below it: standby)
`define SMCP_STBY_FREQ_KHZ 500
// lock expected within this time, milliseconds
`define SMCP_LOCK_MS 2

`define SMCP_GLITCH_CYC \
    ((`SMCP_GLITCH_US * 1000 + `SMCP_CLK_PERIOD_NS - 1) / `SMCP_CLK_PERIOD_NS)
`define SMCP_IDLE_CYC \
    ((1000000 / `SMCP_STBY_FREQ_KHZ) / `SMCP_CLK_PERIOD_NS)
`define SMCP_LOCK_CYC \
    ((`SMCP_LOCK_MS * 1000000) / `SMCP_CLK_PERIOD_NS)

// frame layout
`define SMCP_FRAME_W 30
`define SMCP_PIX_W 24
`define SMCP_POS_VSYNC 24
`define SMCP_POS_HSYNC 25
`define SMCP_POS_VALID 26
`define SMCP_POS_PARITY 27
`define SMCP_POS_RSV0 28
`define SMCP_POS_RSV1 29
`define SMCP_RSV_VALUE 1'h0

// lane select codes {high, low}
`define SMCP_LS_ONE 2'h0
`define SMCP_LS_TWO 2'h1
`define SMCP_LS_THREE 2'h2
`define SMCP_LS_RSV 2'h3

// bits per lane per frame
`define SMCP_LEN_ONE 5'h1e
`define SMCP_LEN_TWO 5'h0f
`define SMCP_LEN_THREE 5'h0a

`endif

// ==== verilog/smcp_en_filter.v ====
`timescale 1ns/10ps
// level is accepted only after it has differed from the output for CNT
// cycles; the first sample after reset is taken at once (power-up case)
module smcp_en_filter #(
    parameter CNT = 500,
    parameter CW = 10
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_level,
    output reg o_level
);
    reg init_q;
    reg [CW-1:0] cnt_q;
    localparam integer LAST_N = CNT - 1;
    localparam [CW-1:0] LAST = LAST_N[CW-1:0];

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            init_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
            o_level <= 1'b0;
        end else if (!init_q) begin
            init_q <= 1'b1;
            o_level <= i_level;
        end else if (i_level == o_level) begin
            cnt_q <= {CW{1'b0}};
        end else if (cnt_q == LAST) begin
            cnt_q <= {CW{1'b0}};
            o_level <= i_level;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // smcp_en_filter

// ==== verilog/smcp_frame_buf.v ====
`timescale 1ns/10ps
module smcp_frame_buf #(
    parameter W = 30
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_flush,
    input wire i_in_valid,
    output reg o_in_ready,
    input wire [W-1:0] i_in_data,
    output reg o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;
    reg [1:0] cnt_d;

    assign push = i_in_valid & o_in_ready;
    assign pop = i_out_ready & o_out_valid;
    assign o_out_data = mem_q[rd_q];

    always @* begin
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 2'h1;
        else if (pop && !push)
            cnt_d = cnt_q - 2'h1;
    end

    always @(posedge i_clk) begin
        if (push)
            mem_q[wr_q] <= i_in_data;
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
            o_in_ready <= 1'b1;
            o_out_valid <= 1'b0;
        end else if (i_flush) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
            o_in_ready <= 1'b1;
            o_out_valid <= 1'b0;
        end else begin
            if (push)
                wr_q <= ~wr_q;
            if (pop)
                rd_q <= ~rd_q;
            cnt_q <= cnt_d;
            o_in_ready <= (cnt_d != 2'h2);
            o_out_valid <= (cnt_d != 2'h0);
        end
    end
endmodule // smcp_frame_buf

// ==== verilog/smcp_top.v ====
`include "smcp_consts.vh"
`timescale 1ns/10ps
module smcp_top #(
    parameter LOCK_CYC = `SMCP_LOCK_CYC,
    parameter LOCK_W = 17
) (
    input wire i_clk,
    input wire i_arst_n,
    input wire i_transmitter_enable_pin,
    input wire i_pclk,
    input wire [23:0] i_pixel,
    input wire i_vertical_sync_in,
    input wire i_horizontal_sync_in,
    input wire i_pixel_valid_in,
    input wire i_lane_select_low,
    input wire i_lane_select_high,
    input wire i_pll_locked,
    input wire i_bit_en,
    output reg o_pll_enable,
    output reg o_monitor_on,
    output reg o_fwd_clk,
    output reg o_fwd_clk_oe,
    output reg o_serial_lane_zero,
    output reg o_serial_lane_zero_oe,
    output reg o_serial_lane_one,
    output reg o_serial_lane_one_oe,
    output reg o_serial_lane_two,
    output reg o_serial_lane_two_oe,
    output reg [3:0] o_mode,
    output wire o_capture_ready,
    output reg o_capture_drop
);
    localparam [7:0] ST_SHUT = 8'h01;
    localparam [7:0] ST_STBY = 8'h02;
    localparam [7:0] ST_ACQ = 8'h04;
    localparam [7:0] ST_TXL = 8'h08;
    localparam [7:0] ST_TXC = 8'h10;
    localparam [7:0] ST_TX = 8'h20;
    localparam [7:0] ST_DNC = 8'h40;
    localparam [7:0] ST_DND = 8'h80;

    localparam integer IDLE_N = `SMCP_IDLE_CYC;
    localparam [6:0] IDLE_LAST = IDLE_N[6:0];
    localparam integer LOCK_N = LOCK_CYC - 1;
    localparam [LOCK_W-1:0] LOCK_LAST = LOCK_N[LOCK_W-1:0];
    localparam integer FRAME_LAST_N = `SMCP_FRAME_W - 1;
    localparam [6:0] FRAME_LAST = FRAME_LAST_N[6:0];

    reg [7:0] state_q;
    reg [7:0] state_d;
    wire en_filt;
    reg pclk_prev_q;
    wire pclk_rise;
    reg [6:0] idle_cnt_q;
    reg active_q;
    reg [LOCK_W-1:0] lock_cnt_q;
    reg lock_tmo_q;

    reg [`SMCP_FRAME_W-1:0] frame_q;
    reg [`SMCP_FRAME_W-1:0] frame_d;
    reg [4:0] idx_q;
    reg [4:0] idx_d;
    reg [4:0] len;
    wire [1:0] ls;
    wire tx_path;
    wire [`SMCP_FRAME_W-1:0] cap_frame;
    wire [26:0] payload;
    wire buf_valid;
    wire [`SMCP_FRAME_W-1:0] buf_data;
    reg pop;
    wire push;
    reg [6:0] pos_one;
    reg [6:0] pos_two;
    wire parity;

    smcp_en_filter #(
        .CNT(`SMCP_GLITCH_CYC),
        .CW(10)
    ) u_en_filter (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_level(i_transmitter_enable_pin),
        .o_level(en_filt)
    );

    // pixel clock is a sampled input; its rise marks a pixel
    assign pclk_rise = i_pclk & ~pclk_prev_q;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            pclk_prev_q <= 1'b0;
        else
            pclk_prev_q <= i_pclk;
    end

    // activity monitor: any rise within one 500 kHz period counts as live;
    // faster clocks always qualify, slower ones time out once their period reaches 102 cycles
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idle_cnt_q <= 7'h00;
            active_q <= 1'b0;
        end else if (state_q == ST_SHUT) begin
            idle_cnt_q <= 7'h00;
            active_q <= 1'b0;
        end else if (pclk_rise) begin
            idle_cnt_q <= 7'h00;
            active_q <= 1'b1;
        end else if (idle_cnt_q == IDLE_LAST) begin
            active_q <= 1'b0;
        end else begin
            idle_cnt_q <= idle_cnt_q + 7'h01;
        end
    end

    // lock watchdog: a pll that fails to lock in time is restarted
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lock_cnt_q <= {LOCK_W{1'b0}};
            lock_tmo_q <= 1'b0;
        end else if (state_q != ST_ACQ || lock_tmo_q) begin
            lock_cnt_q <= {LOCK_W{1'b0}};
            lock_tmo_q <= 1'b0;
        end else if (lock_cnt_q == LOCK_LAST) begin
            lock_tmo_q <= 1'b1;
        end else begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_SHUT: begin
                if (en_filt)
                    state_d = ST_STBY;
            end
            ST_STBY: begin
                if (!en_filt)
                    state_d = ST_SHUT;
                else if (active_q)
                    state_d = ST_ACQ;
            end
            ST_ACQ: begin
                if (!en_filt)
                    state_d = ST_SHUT;
                else if (!active_q || lock_tmo_q)
                    state_d = ST_STBY;
                else if (i_pll_locked)
                    state_d = ST_TXL;
            end
            ST_TXL, ST_TXC, ST_TX: begin
                if (!en_filt)
                    state_d = ST_DNC;
                else if (!active_q || !i_pll_locked)
                    state_d = ST_STBY;
                else if (state_q == ST_TXL && buf_valid)
                    state_d = ST_TXC;
                else if (state_q == ST_TXC && i_bit_en)
                    state_d = ST_TX;
            end
            ST_DNC: state_d = ST_DND;
            ST_DND: state_d = ST_SHUT;
            default: state_d = ST_SHUT;
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            state_q <= ST_SHUT;
        else
            state_q <= state_d;
    end

    // lane mode decode
    assign ls = {i_lane_select_high, i_lane_select_low};

    always @* begin
        case (ls)
            `SMCP_LS_ONE: len = `SMCP_LEN_ONE;
            `SMCP_LS_TWO: len = `SMCP_LEN_TWO;
            `SMCP_LS_THREE: len = `SMCP_LEN_THREE;
            // reserved code keeps the one-lane frame length
            `SMCP_LS_RSV: len = `SMCP_LEN_ONE;
            default: len = `SMCP_LEN_ONE;
        endcase
    end

    // frame assembly at the pixel clock rise
    assign payload = {i_pixel_valid_in, i_horizontal_sync_in,
        i_vertical_sync_in, i_pixel};
    assign parity = ~(^payload);
    assign cap_frame = {`SMCP_RSV_VALUE, `SMCP_RSV_VALUE,
        parity, payload};

    assign tx_path = (state_q == ST_TXL) || (state_q == ST_TXC)
        || (state_q == ST_TX);
    assign push = tx_path && pclk_rise;

    smcp_frame_buf #(
        .W(`SMCP_FRAME_W)
    ) u_frame_buf (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_flush(!tx_path),
        .i_in_valid(push),
        .o_in_ready(o_capture_ready),
        .i_in_data(cap_frame),
        .o_out_valid(buf_valid),
        .i_out_ready(pop),
        .o_out_data(buf_data)
    );

    // shift position; at frame end the next frame is taken, and on underrun
    // the last frame repeats so the receiver keeps framing
    // the clock-on step holds bit 0, so the lanes open on the first bit
    always @* begin
        frame_d = frame_q;
        idx_d = idx_q;
        pop = 1'b0;
        if (state_q == ST_TXL) begin
            idx_d = 5'h00;
            if (buf_valid) begin
                frame_d = buf_data;
                pop = 1'b1;
            end
        end else if (state_q == ST_TX && i_bit_en) begin
            if (idx_q >= len - 5'h01) begin
                idx_d = 5'h00;
                if (buf_valid) begin
                    frame_d = buf_data;
                    pop = 1'b1;
                end
            end else begin
                idx_d = idx_q + 5'h01;
            end
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_q <= {`SMCP_FRAME_W{1'b0}};
            idx_q <= 5'h00;
        end else begin
            frame_q <= frame_d;
            idx_q <= idx_d;
        end
    end

    // lanes one and two start len and 2*len bits in; in narrower modes
    // these run past the frame end, so they fall back to bit 0 there
    always @* begin
        pos_one = {2'b00, idx_d} + {2'b00, len};
        pos_two = pos_one + {2'b00, len};
        if (pos_one > FRAME_LAST)
            pos_one = 7'h00;
        if (pos_two > FRAME_LAST)
            pos_two = 7'h00;
    end

    // lane k carries frame bits k*len .. k*len+len-1, lowest first
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_serial_lane_zero <= 1'b0;
            o_serial_lane_one <= 1'b0;
            o_serial_lane_two <= 1'b0;
            o_fwd_clk <= 1'b0;
        end else begin
            o_serial_lane_zero <= frame_d[idx_d];
            o_serial_lane_one <= frame_d[pos_one[4:0]];
            o_serial_lane_two <= frame_d[pos_two[4:0]];
            // divide the bit rate by len: high for the first half frame
            o_fwd_clk <= (idx_d < {1'b0, len[4:1]});
        end
    end

    // output enables and pll/monitor controls
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fwd_clk_oe <= 1'b0;
            o_serial_lane_zero_oe <= 1'b0;
            o_serial_lane_one_oe <= 1'b0;
            o_serial_lane_two_oe <= 1'b0;
            o_pll_enable <= 1'b0;
            o_monitor_on <= 1'b0;
            o_mode <= 4'h1;
            o_capture_drop <= 1'b0;
        end else begin
            o_fwd_clk_oe <= (state_d == ST_TXC)
                || (state_d == ST_TX);
            // lanes stay on through the clock-off step of a shutdown
            o_serial_lane_zero_oe <= (state_d == ST_TX
                || (state_d == ST_DNC && o_serial_lane_zero_oe))
                && (ls != `SMCP_LS_RSV);
            o_serial_lane_one_oe <= (state_d == ST_TX
                || (state_d == ST_DNC && o_serial_lane_one_oe))
                && (ls == `SMCP_LS_TWO
                || ls == `SMCP_LS_THREE);
            o_serial_lane_two_oe <= (state_d == ST_TX
                || (state_d == ST_DNC && o_serial_lane_two_oe))
                && (ls == `SMCP_LS_THREE);
            o_pll_enable <= (state_d == ST_ACQ) || (state_d == ST_TXL)
                || (state_d == ST_TXC) || (state_d == ST_TX)
                || (state_d == ST_DNC);
            o_monitor_on <= (state_d != ST_SHUT)
                && (state_d != ST_DND);
            // the clock-off step already reports standby
            o_mode[0] <= (state_d == ST_SHUT) || (state_d == ST_DND);
            o_mode[1] <= (state_d == ST_STBY) || (state_d == ST_DNC);
            o_mode[2] <= (state_d == ST_ACQ);
            o_mode[3] <= (state_d == ST_TXL) || (state_d == ST_TXC)
                || (state_d == ST_TX);
            // pixel lost because both buffer slots were full
            o_capture_drop <= push && !o_capture_ready;
        end
    end
endmodule // smcp_top
